// ### core/fspc_ctrl.sv
`timescale 1ns/100ps
module fspc_ctrl
   import fspc_pkg::*;
#(
   parameter int OP_CYCLES = FSPC_OP_CYCLES,
   parameter int ROWS = FSPC_PANEL_ROWS * 4
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tbl_valid,
   input wire logic tbl_write,
   input wire logic tbl_high,
   input wire logic tbl_byte,
   input wire logic [15:0] tbl_ea,
   input wire logic [15:0] tbl_wdata,
   output logic [15:0] tbl_rdata,
   output logic tbl_done,
   output logic core_stall
);
   // ****************************************
   // storage
   // ****************************************
   localparam int RW = $clog2(ROWS);
   logic [23:0] flash_mem [ROWS*FSPC_ROW_WORDS];
   logic [23:0] latch_mem [FSPC_ROW_WORDS];
   logic [15:0] ctl_q, ctl_d;
   logic [15:0] adl_q, adl_d;
   logic [7:0] adh_q, adh_d;
   logic [7:0] page_q, page_d;
   logic [1:0] key_q, key_d;
   logic [4:0] lidx_q, lidx_d;
   logic seq_err_q, seq_err_d;
   logic [31:0] cnt_q, cnt_d;
   fspc_state_t st_q, st_d;
   logic [31:0] prdata_d;
   logic pready_q, pslverr_d;
   logic [15:0] trd_d;
   logic done_q, done_d, tph_q, tph_d;
   logic wr_acc, start_ok;
   logic [23:0] tbl_addr;
   logic [RW+4:0] word_ix;
   logic [RW+4:0] op_word;

   function automatic logic [RW+4:0] fspc_word(input logic [23:0] a);
      fspc_word = a[RW+5:1];
   endfunction : fspc_word

   assign tbl_addr = {page_q, tbl_ea};
   assign word_ix = fspc_word(tbl_addr);
   assign op_word = fspc_word({adh_q, adl_q});
   assign wr_acc = psel && penable && pwrite && !pready_q;
   assign start_ok = wr_acc && paddr == FSPC_OFF_CONTROL
      && pwdata[FSPC_CTL_START_BIT] && pwdata[FSPC_CTL_WRITE_ENABLE_BIT_BIT]
      && key_q == 2'd2 && st_q == FSPC_IDLE;

   // ****************************************
   // next values
   // ****************************************
   always_comb
   begin
      ctl_d = ctl_q;
      adl_d = adl_q;
      adh_d = adh_q;
      page_d = page_q;
      key_d = key_q;
      lidx_d = lidx_q;
      seq_err_d = seq_err_q;
      cnt_d = cnt_q;
      st_d = st_q;
      prdata_d = 32'h0000_0000;
      pslverr_d = 1'b0;
      trd_d = tbl_rdata;
      done_d = 1'b0;
      tph_d = 1'b0;
      if (wr_acc)
      begin
         case (paddr)
            FSPC_OFF_CONTROL:
            begin
               if (st_q == FSPC_IDLE)
                  ctl_d = pwdata[15:0] & FSPC_CTL_WMASK;
               key_d = 2'd0;
            end
            FSPC_OFF_ADDR_LOW:
               adl_d = pwdata[15:0];
            FSPC_OFF_ADDR_HIGH:
               adh_d = pwdata[7:0];
            FSPC_OFF_KEY:
               if (pwdata[7:0] == FSPC_KEY_FIRST)
                  key_d = 2'd1;
               else if (key_q == 2'd1 && pwdata[7:0] == FSPC_KEY_SECOND)
                  key_d = 2'd2;
               else
                  key_d = 2'd0;
            FSPC_OFF_PAGE:
               page_d = pwdata[7:0];
            FSPC_OFF_STATUS:;
            default:
               pslverr_d = 1'b1;
         endcase
         if (start_ok)
            ctl_d[FSPC_CTL_START_BIT] = 1'b1;
      end
      else if (psel && penable && !pready_q)
      begin
         case (paddr)
            FSPC_OFF_CONTROL: prdata_d = {16'h0000, ctl_q};
            FSPC_OFF_ADDR_LOW: prdata_d = {16'h0000, adl_q};
            FSPC_OFF_ADDR_HIGH: prdata_d = {24'h000000, adh_q};
            FSPC_OFF_KEY: prdata_d = 32'h0000_0000;
            FSPC_OFF_PAGE: prdata_d = {24'h000000, page_q};
            FSPC_OFF_STATUS:
               prdata_d = {24'h000000, seq_err_q, lidx_q, 2'b00};
            default: pslverr_d = 1'b1;
         endcase
      end
      if (tbl_valid && st_q == FSPC_IDLE && !tph_q && !done_q)
      begin
         adl_d = tbl_addr[15:0];
         adh_d = tbl_addr[23:16];
         if (tbl_write)
         begin
            tph_d = 1'b1;
            if (tbl_high)
            begin
               if (tbl_addr[5:1] != lidx_q)
                  seq_err_d = 1'b1;
               lidx_d = tbl_addr[5:1] + 5'd1;
            end
         end
         else
         begin
            done_d = 1'b1;
            if (tbl_high)
               trd_d = {8'h00, flash_mem[word_ix][23:16]};
            else if (tbl_byte)
               trd_d = {8'h00, tbl_ea[0] ? flash_mem[word_ix][15:8]
                  : flash_mem[word_ix][7:0]};
            else
               trd_d = flash_mem[word_ix][15:0];
         end
      end
      if (tph_q)
         done_d = 1'b1;
      case (st_q)
         FSPC_IDLE:
            if (start_ok)
            begin
               st_d = FSPC_BUSY;
               cnt_d = 32'd0;
               key_d = 2'd0;
            end
         FSPC_BUSY:
            if (cnt_q == 32'(OP_CYCLES - 2))
               st_d = FSPC_DONE;
            else
               cnt_d = cnt_q + 32'd1;
         FSPC_DONE:
         begin
            st_d = FSPC_IDLE;
            ctl_d[FSPC_CTL_START_BIT] = 1'b0;
            lidx_d = 5'd0;
            seq_err_d = 1'b0;
         end
         default: st_d = FSPC_IDLE;
      endcase
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctl_q <= FSPC_RST_CONTROL;
         adl_q <= FSPC_RST_ADDR;
         adh_q <= FSPC_RST_ADDR[7:0];
         page_q <= FSPC_RST_PAGE;
         key_q <= 2'd0;
         lidx_q <= 5'd0;
         seq_err_q <= 1'b0;
         cnt_q <= 32'd0;
         st_q <= FSPC_IDLE;
         prdata <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr <= 1'b0;
         tbl_rdata <= 16'h0000;
         done_q <= 1'b0;
         tph_q <= 1'b0;
         core_stall <= 1'b0;
      end
      else
      begin
         ctl_q <= ctl_d;
         adl_q <= adl_d;
         adh_q <= adh_d;
         page_q <= page_d;
         key_q <= key_d;
         lidx_q <= lidx_d;
         seq_err_q <= seq_err_d;
         cnt_q <= cnt_d;
         st_q <= st_d;
         prdata <= prdata_d;
         pready_q <= psel && penable && !pready_q;
         pslverr <= pslverr_d;
         tbl_rdata <= trd_d;
         done_q <= done_d;
         tph_q <= tph_d;
         core_stall <= st_d != FSPC_IDLE;
      end
   end
   assign pready = pready_q;
   assign tbl_done = done_q;

   // ****************************************
   // latch and array memory
   // ****************************************
   always_ff @(posedge pclk)
   begin
      if (tph_d && tbl_valid)
      begin
         if (tbl_high)
            latch_mem[tbl_addr[5:1]][23:16] <= tbl_wdata[7:0];
         else if (tbl_byte && tbl_ea[0])
            latch_mem[tbl_addr[5:1]][15:8] <= tbl_wdata[7:0];
         else if (tbl_byte)
            latch_mem[tbl_addr[5:1]][7:0] <= tbl_wdata[7:0];
         else
            latch_mem[tbl_addr[5:1]][15:0] <= tbl_wdata;
      end
      if (st_q == FSPC_DONE)
      begin
         for (int i = 0; i < FSPC_ROW_WORDS; i++)
         begin
            if (ctl_q[6])
               flash_mem[{op_word[RW+4:5], 5'(i)}] <= 24'hffffff;
            else
               flash_mem[{op_word[RW+4:5], 5'(i)}] <= latch_mem[i];
         end
      end
   end

   // ****************************************
   // checks
   // ****************************************
   sequence s_start;
      start_ok;
   endsequence
   property p_busy_len;
      @(posedge pclk) disable iff (!presetn)
      s_start |=> (st_q == FSPC_BUSY) [*8];
   endproperty
   a_busy_len: assert property (p_busy_len)
      else $error("operation ended early");
   property p_stall;
      @(posedge pclk) disable iff (!presetn)
      st_q == FSPC_BUSY |-> core_stall;
   endproperty
   a_stall: assert property (p_stall)
      else $error("core not stalled");
   property p_clear;
      @(posedge pclk) disable iff (!presetn)
      st_q == FSPC_DONE |=> !ctl_q[FSPC_CTL_START_BIT];
   endproperty
   a_clear: assert property (p_clear)
      else $error("start bit not cleared");
   property p_nokey;
      @(posedge pclk) disable iff (!presetn)
      st_q == FSPC_IDLE && key_q != 2'd2 |=> st_q == FSPC_IDLE;
   endproperty
   a_nokey: assert property (p_nokey)
      else $error("start without key");
   property p_capture;
      @(posedge pclk) disable iff (!presetn)
      tbl_valid && st_q == FSPC_IDLE && !tph_q && !done_q
      |=> adl_q == $past(tbl_ea) && adh_q == $past(page_q);
   endproperty
   a_capture: assert property (p_capture)
      else $error("address not captured");
   property p_twr;
      @(posedge pclk) disable iff (!presetn)
      tph_d |=> ##1 tbl_done;
   endproperty
   a_twr: assert property (p_twr)
      else $error("table write not two cycles");
   property p_keyro;
      @(posedge pclk) disable iff (!presetn)
      psel && penable && !pwrite && paddr == FSPC_OFF_KEY && !pready_q
      |=> prdata == 32'h0000_0000;
   endproperty
   a_keyro: assert property (p_keyro)
      else $error("key readable");
   property p_ready;
      @(posedge pclk) disable iff (!presetn)
      psel && penable && !pready_q |=> pready;
   endproperty
   a_ready: assert property (p_ready)
      else $error("apb not answered");
   sequence s_rd_take;
      tbl_valid && !tbl_write && st_q == FSPC_IDLE && !tph_q && !done_q;
   endsequence
   property p_rd_lat;
      @(posedge pclk) disable iff (!presetn)
      s_rd_take |=> tbl_done;
   endproperty
   a_rd_lat: assert property (p_rd_lat)
      else $error("table read not answered");
   property p_done_pulse;
      @(posedge pclk) disable iff (!presetn)
      tbl_done |=> !tbl_done;
   endproperty
   a_done_pulse: assert property (p_done_pulse)
      else $error("table done held");
   property p_busy_hold;
      @(posedge pclk) disable iff (!presetn)
      st_q == FSPC_BUSY |-> ctl_q[FSPC_CTL_START_BIT];
   endproperty
   a_busy_hold: assert property (p_busy_hold)
      else $error("start bit dropped while busy");
   property p_stall_end;
      @(posedge pclk) disable iff (!presetn)
      st_q == FSPC_DONE |=> !core_stall;
   endproperty
   a_stall_end: assert property (p_stall_end)
      else $error("stall held after operation");
   property p_no_tbl_busy;
      @(posedge pclk) disable iff (!presetn)
      st_q != FSPC_IDLE |=> !tph_q;
   endproperty
   a_no_tbl_busy: assert property (p_no_tbl_busy)
      else $error("table write taken while busy");
   property p_key_clr;
      @(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == FSPC_OFF_CONTROL |=> key_q == 2'd0;
   endproperty
   a_key_clr: assert property (p_key_clr)
      else $error("key state kept after control write");
   property p_slverr;
      @(posedge pclk) disable iff (!presetn)
      psel && penable && !pready_q && paddr > FSPC_OFF_STATUS |=> pslverr;
   endproperty
   a_slverr: assert property (p_slverr)
      else $error("unmapped access not flagged");
endmodule : fspc_ctrl

// ### core/fspc_pkg.sv
package fspc_pkg;
   // ****************************************
   // register byte offsets
   // ****************************************
   localparam logic [11:0] FSPC_OFF_CONTROL = 12'h000;
   localparam logic [11:0] FSPC_OFF_ADDR_LOW = 12'h004;
   localparam logic [11:0] FSPC_OFF_ADDR_HIGH = 12'h008;
   localparam logic [11:0] FSPC_OFF_KEY = 12'h00c;
   localparam logic [11:0] FSPC_OFF_PAGE = 12'h010;
   localparam logic [11:0] FSPC_OFF_STATUS = 12'h014;
   // ****************************************
   // control fields and key values
   // ****************************************
   localparam int FSPC_CTL_START_BIT = 15;
   localparam int FSPC_CTL_WRITE_ENABLE_BIT_BIT = 14;
   localparam logic [15:0] FSPC_CTL_WMASK = 16'h407f;
   localparam logic [15:0] FSPC_CTL_ROW_ERASE = 16'h4041;
   localparam logic [15:0] FSPC_CTL_ROW_PROG = 16'h4001;
   localparam logic [7:0] FSPC_KEY_FIRST = 8'h55;
   localparam logic [7:0] FSPC_KEY_SECOND = 8'haa;
   localparam logic [15:0] FSPC_RST_CONTROL = 16'h0000;
   localparam logic [15:0] FSPC_RST_ADDR = 16'h0000;
   localparam logic [7:0] FSPC_RST_PAGE = 8'h00;
   // ****************************************
   // geometry and timing
   // ****************************************
   localparam int FSPC_ROW_WORDS = 32;
   localparam int FSPC_ROW_BYTES = 96;
   localparam int FSPC_PANEL_ROWS = 128;
   localparam int FSPC_CLK_HZ = 10000000;
   localparam int FSPC_OP_TIME_US = 2000;
   localparam int FSPC_OP_CYCLES = FSPC_CLK_HZ / 1000000 * FSPC_OP_TIME_US;
   localparam int FSPC_TBLWR_CYCLES = 2;
   // ****************************************
   // sequencer states
   // ****************************************
   typedef enum logic [2:0]
   {
      FSPC_IDLE = 3'b001,
      FSPC_BUSY = 3'b010,
      FSPC_DONE = 3'b100
   } fspc_state_t;
endpackage : fspc_pkg

// ### tb/fspc_core_model.sv
`timescale 1ns/100ps
// ****
// core side of the table port
// ****
module fspc_core_model
   import fspc_pkg::*;
(
   input wire logic pclk,
   input wire logic tbl_done,
   input wire logic [15:0] tbl_rdata,
   output logic tbl_valid,
   output logic tbl_write,
   output logic tbl_high,
   output logic tbl_byte,
   output logic [15:0] tbl_ea,
   output logic [15:0] tbl_wdata
);
   initial
   begin
      tbl_valid = 1'h0;
      tbl_write = 1'h0;
      tbl_high = 1'h0;
      tbl_byte = 1'h0;
      tbl_ea = 16'h0000;
      tbl_wdata = 16'h0000;
   end
   // one op {write,high,byte}, held until done
   task automatic op(input logic [2:0] m, input logic [15:0] ea,
      input logic [15:0] wd, output logic [15:0] rd, output int n);
      n = 0;
      @(posedge pclk);
      {tbl_write, tbl_high, tbl_byte} <= m;
      tbl_ea <= ea;
      tbl_wdata <= wd;
      tbl_valid <= 1'h1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (tbl_done !== 1'h1 && n < 50);
      rd = tbl_rdata;
      tbl_valid <= 1'h0;
      tbl_ea <= ~ea;
      tbl_wdata <= ~wd;
   endtask : op
endmodule : fspc_core_model

// ### tb/fspc_ctrl_tb.sv
`timescale 1ns/100ps
module fspc_ctrl_tb;
   import fspc_pkg::*;
   localparam int OPC = 20;
   localparam logic [15:0] ROW_A = 16'h0800;
   localparam logic [15:0] ROW_B = 16'h0840;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic tbl_valid, tbl_write, tbl_high, tbl_byte, tbl_done, core_stall;
   logic [15:0] tbl_ea, tbl_wdata, tbl_rdata, td;
   int mismatches, num_checks, n, i;
   fspc_ctrl #(.OP_CYCLES(OPC), .ROWS(2048)) dut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tbl_valid(tbl_valid), .tbl_write(tbl_write),
      .tbl_high(tbl_high), .tbl_byte(tbl_byte), .tbl_ea(tbl_ea),
      .tbl_wdata(tbl_wdata), .tbl_rdata(tbl_rdata), .tbl_done(tbl_done),
      .core_stall(core_stall));
   fspc_core_model core (.pclk(pclk), .tbl_done(tbl_done),
      .tbl_rdata(tbl_rdata), .tbl_valid(tbl_valid), .tbl_write(tbl_write),
      .tbl_high(tbl_high), .tbl_byte(tbl_byte), .tbl_ea(tbl_ea),
      .tbl_wdata(tbl_wdata));
   // ****
   // tasks
   // ****
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e)
      begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'h1 && k < 20);
      if (pready !== 1'h1)
         mismatches++;
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   task automatic run(input logic [15:0] c, input logic [7:0] k,
      output int s);
      apb(1'h1, FSPC_OFF_CONTROL, {16'h0000, c});
      apb(1'h1, FSPC_OFF_KEY, {24'h0, FSPC_KEY_FIRST});
      apb(1'h1, FSPC_OFF_KEY, {24'h0, k});
      apb(1'h1, FSPC_OFF_CONTROL, {16'h0000, c | 16'h8000});
      s = 0;
      repeat (4 * OPC) // count cycles the core is stalled after start
      begin
         if (core_stall === 1'h1)
            s++;
         @(posedge pclk);
      end
   endtask : run
   task automatic rdw(input logic [15:0] ea, input logic [23:0] e);
      core.op(3'h0, ea, 16'h0000, td, n);
      chk(n, 2);
      chk({16'h0000, td}, {8'h00, e[15:0]});
      core.op(3'h2, ea, 16'h0000, td, n);
      chk(n, 2);
      chk({24'h0, td[7:0]}, {24'h0, e[23:16]});
   endtask : rdw
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   // ****
   // clock, watchdog, tests
   // ****
   initial
   begin
      pclk = 1'h0;
      forever #50 pclk = ~pclk;
   end
   initial
   begin
      #1000000;
      mismatches++;
      wrap_up();
   end
   initial
   begin
      mismatches = 0;
      num_checks = 0;
      presetn = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (4) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, FSPC_OFF_CONTROL, 32'h0);
      chk(rd, {16'h0000, FSPC_RST_CONTROL});
      apb(1'h0, 12'h040, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'h1, FSPC_OFF_ADDR_LOW, 32'h1234);
      apb(1'h1, FSPC_OFF_ADDR_HIGH, 32'h56);
      apb(1'h0, FSPC_OFF_ADDR_LOW, 32'h0);
      chk(rd, 32'h1234);
      apb(1'h0, FSPC_OFF_ADDR_HIGH, 32'h0);
      chk(rd, 32'h56);
      apb(1'h1, FSPC_OFF_PAGE, 32'h1);
      core.op(3'h0, ROW_A, 16'h0000, td, n);
      chk(n, 2);
      apb(1'h0, FSPC_OFF_ADDR_LOW, 32'h0);
      chk(rd, {16'h0000, ROW_A});
      apb(1'h0, FSPC_OFF_ADDR_HIGH, 32'h0);
      chk(rd, 32'h1);
      run(FSPC_CTL_ROW_ERASE, 8'h00, n);
      chk(n, 0);
      run(16'h0041, FSPC_KEY_SECOND, n);
      chk(n, 0);
      run(FSPC_CTL_ROW_ERASE, FSPC_KEY_SECOND, n);
      chk(n, OPC);
      apb(1'h0, FSPC_OFF_CONTROL, 32'h0);
      chk({31'h0, rd[15]}, 32'h0);
      rdw(ROW_A + 16'h3e, 24'hffffff);
      core.op(3'h6, ROW_A + 16'h6, 16'h0000, td, n);
      chk(n, 1 + FSPC_TBLWR_CYCLES);
      apb(1'h0, FSPC_OFF_STATUS, 32'h0);
      chk(rd, 32'h90);
      for (i = 0; i < FSPC_ROW_WORDS; i++)
      begin
         core.op(3'h4, ROW_A + 16'(2 * i), 16'ha500 + 16'(i), td, n);
         chk(n, 1 + FSPC_TBLWR_CYCLES);
         core.op(3'h6, ROW_A + 16'(2 * i), 16'hee40 + 16'(i), td, n);
         chk(n, 1 + FSPC_TBLWR_CYCLES);
      end
      core.op(3'h5, ROW_A + 16'h3, 16'hcc5a, td, n);
      chk(n, 1 + FSPC_TBLWR_CYCLES);
      rdw(ROW_A, 24'hffffff);
      run(FSPC_CTL_ROW_PROG, FSPC_KEY_SECOND, n);
      chk(n, OPC);
      apb(1'h0, FSPC_OFF_STATUS, 32'h0);
      chk(rd, 32'h0);
      for (i = 0; i < FSPC_ROW_WORDS; i++)
         rdw(ROW_A + 16'(2 * i), {8'h40 + 8'(i),
            i == 1 ? 16'h5a01 : 16'ha500 + 16'(i)});
      core.op(3'h1, ROW_A + 16'h1, 16'h0000, td, n);
      chk({24'h0, td[7:0]}, 32'ha5);
      apb(1'h1, FSPC_OFF_ADDR_LOW, {16'h0000, ROW_B});
      run(FSPC_CTL_ROW_ERASE, FSPC_KEY_SECOND, n);
      chk(n, OPC);
      rdw(ROW_B, 24'hffffff);
      rdw(ROW_A + 16'h3e, 24'h5fa51f);
      apb(1'h0, FSPC_OFF_CONTROL, 32'h0);
      chk({31'h0, rd[15]}, 32'h0);
      wrap_up();
   end
endmodule : fspc_ctrl_tb
